// ---- pkg/drt_consts.vh ----
`ifndef DRT_CONSTS_VH
`define DRT_CONSTS_VH
// =====================================
// register address and reset
`define DRT_CTRL_ADDR 8'hC8
`define DRT_CTRL_RESET 8'h00
// =====================================
// control bit positions
`define DRT_BIT_HIGH_OVF 7
`define DRT_BIT_LOW_OVF 6
`define DRT_BIT_LOW_IRQ_EN 5
`define DRT_BIT_CAPTURE_EN 4
`define DRT_BIT_SPLIT 3
`define DRT_BIT_RUN 2
`define DRT_BIT_UNUSED 1
`define DRT_BIT_EXT_CLK 0
// =====================================
// prescaler counts
`define DRT_SYS_DIV 4'd12
`define DRT_EXT_DIV 4'd8
`endif

// ---- design/drt_edge_sync.v ----
`timescale 1ns/1ps
// =====================================
// three-stage synchroniser; stage 1 feeds only stage 2
module drt_edge_sync (
   input wire core_clk,
   input wire rst,
   input wire async_in,
   output reg level_q,
   output wire fall_pulse,
   output wire rise_pulse
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a change counts once stages two and three agree
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
   assign fall_pulse = level_q & ~s3_q & (s2_q == s3_q);
   assign rise_pulse = ~level_q & s3_q & (s2_q == s3_q);
endmodule

// ---- design/drt_timer.v ----
`timescale 1ns/1ps
`include "drt_consts.vh"
// Overview of operation
// - high byte overflow from FF to the reload_high_byte value sets the high-byte overflow flag.
// - in 16-bit mode that flag sets when the full counter wraps.
// - with timer interrupt enabled, a set high flag requests an interrupt.
// - overflow flags are never cleared by hardware; only software clears them.
// - low byte wrap sets the low-byte flag in every mode.
// - low-byte irq enable plus timer interrupt enable requests on low overflow.
// - capture mode copies the 16-bit count to reload on oscillator falling edge.
// - capture mode plus timer interrupt enable requests on each capture.
// - split bit zero gives one 16-bit counter, one gives two 8-bit counters.
// - counting only while run bit is one, except the low byte in split mode; zero stops 16-bit counting.
// - in split mode run gates only the high byte; low byte always counts.
// - clock select zero uses system clock over 12, one external over 8.
// - per-byte choice bits pick between the selected timebase and the undivided system clock; the high one only in split mode.
// - control bit one reads zero and ignores writes.
// - control register sits at C8, bit-addressable, resets to zero.
module drt_timer (
   input wire core_clk,
   input wire rst,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire sfr_bit_wr,
   input wire [2:0] sfr_bit_sel,
   input wire sfr_bit_val,
   output wire [7:0] sfr_rdata,
   input wire timer_irq_enable,
   input wire high_byte_clock_choice,
   input wire low_byte_clock_choice,
   input wire ext_clk_pin,
   input wire lfo_out_pin,
   input wire [7:0] reload_high_byte,
   input wire [7:0] reload_low_byte,
   output reg [7:0] counter_high_byte,
   output reg [7:0] counter_low_byte,
   output reg [7:0] capture_high_byte,
   output reg [7:0] capture_low_byte,
   output reg capture_valid_q,
   output wire irq_req
);
   // =====================================
   // control register
   reg [7:0] ctrl_q;
   reg [7:0] ctrl_d;
   wire sel = (sfr_addr == `DRT_CTRL_ADDR);
   wire high_ovf;
   wire low_ovf;
   wire capture_evt;
   wire split = ctrl_q[`DRT_BIT_SPLIT];
   wire run = ctrl_q[`DRT_BIT_RUN];
   wire ext_sel = ctrl_q[`DRT_BIT_EXT_CLK];
   // a whole-byte write and a bit write in one cycle: the whole byte wins
   always @* begin
      ctrl_d = ctrl_q;
      if (sel && sfr_wr) begin
         ctrl_d = sfr_wdata;
      end else if (sel && sfr_bit_wr) begin
         ctrl_d[sfr_bit_sel] = sfr_bit_val;
      end
      // hardware set wins over a software clear in the same cycle
      if (high_ovf) begin
         ctrl_d[`DRT_BIT_HIGH_OVF] = 1'b1;
      end
      if (low_ovf) begin
         ctrl_d[`DRT_BIT_LOW_OVF] = 1'b1;
      end
      ctrl_d[`DRT_BIT_UNUSED] = 1'b0;
   end
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `DRT_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end
   // read path is a plain mux so a read needs no wait state
   assign sfr_rdata = sel ? ctrl_q : 8'h00;
   // =====================================
   // pin synchronisers
   wire ext_rise;
   wire lfo_fall;
   drt_edge_sync u_ext_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(ext_clk_pin),
      .level_q(),
      .fall_pulse(),
      .rise_pulse(ext_rise)
   );
   drt_edge_sync u_lfo_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(lfo_out_pin),
      .level_q(),
      .fall_pulse(lfo_fall),
      .rise_pulse()
   );
   // =====================================
   // prescalers
   reg [3:0] sys_div_q;
   reg [2:0] ext_div_q;
   wire sys_tick = (sys_div_q == `DRT_SYS_DIV - 4'd1);
   // the divider wraps by itself, so the tick is its last count
   wire ext_tick = ext_rise && ({1'b0, ext_div_q} == `DRT_EXT_DIV - 4'd1);
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sys_div_q <= 4'h0;
         ext_div_q <= 3'h0;
      end else begin
         sys_div_q <= sys_tick ? 4'h0 : sys_div_q + 4'd1;
         if (ext_rise) begin
            ext_div_q <= ext_div_q + 3'd1; // wraps after eight edges
         end
      end
   end
   // timebase is divided clock; external up to core_clk / 4 (each level held two clocks) is seen
   wire base_tick = ext_sel ? ext_tick : sys_tick;
   // per-byte choice: 1 = system clock undivided, 0 = selected timebase
   // the high choice only matters in split mode, where the high byte has its own clock
   reg hi_tick;
   reg lo_tick;
   always @* begin
      hi_tick = base_tick;
      lo_tick = base_tick;
      if (split && high_byte_clock_choice) begin
         hi_tick = 1'b1;
      end
      if (low_byte_clock_choice) begin
         lo_tick = 1'b1;
      end
   end
   // =====================================
   // counters
   // in 16-bit mode the high byte is a carry stage of the low byte, so both share one tick;
   // in split mode the low byte ignores the run bit by design
   reg lo_en;
   reg hi_en;
   always @* begin
      if (split) begin
         lo_en = lo_tick;
         hi_en = run & hi_tick;
      end else begin
         lo_en = run & lo_tick;
         hi_en = run & lo_tick & (counter_low_byte == 8'hFF);
      end
   end
   assign low_ovf = lo_en && (counter_low_byte == 8'hFF);
   assign high_ovf = hi_en && (counter_high_byte == 8'hFF);
   assign capture_evt = ctrl_q[`DRT_BIT_CAPTURE_EN] && lfo_fall;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         counter_low_byte <= 8'h00;
         counter_high_byte <= 8'h00;
      end else begin
         if (low_ovf) begin
            if (split) begin
               counter_low_byte <= reload_low_byte;
            end else if (high_ovf) begin
               counter_low_byte <= reload_low_byte;
            end else begin
               counter_low_byte <= 8'h00;
            end
         end else if (lo_en) begin
            counter_low_byte <= counter_low_byte + 8'd1;
         end
         if (high_ovf) begin
            counter_high_byte <= reload_high_byte;
         end else if (hi_en) begin
            counter_high_byte <= counter_high_byte + 8'd1;
         end
      end
   end
   // =====================================
   // capture into reload pair; the host reload store takes capture_* on capture_valid_q
   // the value is the count before the edge that raises capture_valid_q;
   // a capture that meets a reload in one cycle leaves the choice to the reload store
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         capture_high_byte <= 8'h00;
         capture_low_byte <= 8'h00;
         capture_valid_q <= 1'b0;
      end else begin
         capture_valid_q <= capture_evt;
         if (capture_evt) begin
            capture_high_byte <= counter_high_byte;
            capture_low_byte <= counter_low_byte;
         end
      end
   end
   // =====================================
   // interrupt request: level while a flag stands, pulse for capture
   // a capture request lasts one cycle, so the processor side must latch it
   wire high_irq_src = ctrl_q[`DRT_BIT_HIGH_OVF];
   wire low_irq_src = ctrl_q[`DRT_BIT_LOW_IRQ_EN] & ctrl_q[`DRT_BIT_LOW_OVF];
   wire cap_irq_src = capture_valid_q;
   assign irq_req = timer_irq_enable & (high_irq_src | low_irq_src | cap_irq_src);
endmodule

// ---- testbench/drt_timer_checker.sv ----
`timescale 1ns/1ps
module drt_timer_checker (
   input wire core_clk,
   input wire rst,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_bit_wr,
   input wire [7:0] sfr_rdata,
   input wire timer_irq_enable,
   input wire [7:0] counter_high_byte,
   input wire [7:0] counter_low_byte,
   input wire irq_req
);
   // flags are visible only while the control address is selected
   wire sel = sfr_addr == 8'hC8;
   wire nw = !sfr_wr && !sfr_bit_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_unused_zero: assert property (sel |-> !sfr_rdata[1]) else $error("bit 1 set");
   a_unmapped_zero: assert property (!sel |-> sfr_rdata == 8'h00) else $error("unmapped read");
   a_high_sticky: assert property (sel && nw && sfr_rdata[7] ##1 sel |-> sfr_rdata[7]) else $error("high lost");
   a_low_sticky: assert property (sel && nw && sfr_rdata[6] ##1 sel |-> sfr_rdata[6]) else $error("low lost");
   a_high_irq: assert property (sel && timer_irq_enable && sfr_rdata[7] |-> irq_req) else $error("no irq");
   a_low_irq: assert property (sel && timer_irq_enable && sfr_rdata[6] && sfr_rdata[5] |-> irq_req)
      else $error("no low irq");
   a_irq_gated: assert property (!timer_irq_enable |-> !irq_req) else $error("irq masked");
   a_stop_holds: assert property (sel && nw && sfr_rdata[3:2] == 2'b00 |=> $stable({counter_high_byte,
      counter_low_byte})) else $error("count moved");
   cover property (irq_req && sfr_rdata[7]);
   cover property (sel && sfr_rdata[3] && sfr_rdata[6]);
   cover property (sel && sfr_rdata[4] && irq_req);
endmodule
bind drt_timer drt_timer_checker i_drt_timer_checker (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_bit_wr,
   .sfr_rdata, .timer_irq_enable, .counter_high_byte, .counter_low_byte, .irq_req);

// ---- testbench/drt_timer_bench.sv ----
`timescale 1ns/1ps
module drt_timer_bench;
   reg core_clk = 0, rst = 1, wr = 0, bwr = 0, bv = 0, ie = 1, hc = 1, lc = 1, ext = 0, lfo = 1;
   reg [7:0] ad = 8'hC8, wd = 8'h00, rh = 8'h00, rl = 8'h00, e, x, h0, l0;
   reg [2:0] bs = 3'h0;
   reg [31:0] s = 32'hE2F5B4F3;
   wire [7:0] rd, ch, cl, kh, kl;
   wire kv, irq;
   integer mismatches = 0, samples_checked = 0, cyc = 0, i;
   drt_timer i_drt_timer (.core_clk(core_clk), .rst(rst), .sfr_addr(ad), .sfr_wdata(wd), .sfr_wr(wr),
      .sfr_bit_wr(bwr), .sfr_bit_sel(bs), .sfr_bit_val(bv), .sfr_rdata(rd), .timer_irq_enable(ie),
      .high_byte_clock_choice(hc), .low_byte_clock_choice(lc), .ext_clk_pin(ext), .lfo_out_pin(lfo),
      .reload_high_byte(rh), .reload_low_byte(rl), .counter_high_byte(ch), .counter_low_byte(cl),
      .capture_high_byte(kh), .capture_low_byte(kl), .capture_valid_q(kv), .irq_req(irq));
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   // pin toggles every two clocks so the synchroniser sees it settle; a rise per four clocks
   always @(posedge core_clk) begin
      if (cyc[0]) ext <= ~ext;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end
   function [31:0] xs(input [31:0] v); begin
      xs = v ^ (v << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   end endfunction
   function [7:0] ctl(input [7:0] v); ctl = v & 8'hFD; endfunction
   task chk(input [15:0] g, input [15:0] w); begin
      samples_checked = samples_checked + 1;
      if (g !== w) begin
         mismatches = mismatches + 1;
         $display("mismatch %0t got %h exp %h", $time, g, w);
      end
   end endtask
   task tk(input integer n); begin
      repeat (n) @(posedge core_clk);
      #1;
   end endtask
   // b selects a single-bit write: d[2:0] picks the bit, d[3] its value
   task wb(input b, input [7:0] d); begin
      @(posedge core_clk);
      {bwr, wr} <= {b, !b};
      {bs, bv, wd} <= {d[2:0], d[3], d};
      tk(1);
      {bwr, wr} <= 2'b00;
   end endtask
   task summarize; begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      tk(1);
      chk(rd, 16'h0000);
      s = xs(s);
      ad <= s[7:0] | 8'h01;
      wb(0, 8'hFF);
      chk(rd, 16'h0000);
      ad <= 8'hC8;
      wb(0, 8'hFF);
      chk(rd, ctl(8'hFF));
      e = 8'hFF;
      for (i = 0; i < 16; i = i + 1) begin
         s = xs(s);
         e[s[2:0]] = s[3];
         wb(1, s[7:0]);
         chk(rd, ctl(e));
      end
      $display("register test done");
      s = xs(s);
      {rh, rl} <= s[15:0];
      wb(0, 8'h2C);
      for (i = 0; i < 600 && rd[7] !== 1'b1; i = i + 1) tk(1);
      x = ch - rh;
      chk({15'h0000, x < 8'h02}, 16'h0001);
      tk(260);
      chk({rd & 8'hC0, 7'h00, irq}, 16'hC001);
      wb(0, 8'h08);
      {h0, l0} = {ch, cl};
      tk(20);
      chk({ch, 7'h00, cl === l0}, {h0, 8'h00});
      ie <= 1'b0;
      wb(0, 8'h00);
      {h0, l0} = {ch, cl};
      tk(20);
      chk({ch, cl}, {h0, l0});
      ie <= 1'b1;
      lc <= 1'b0;
      {rh, rl} <= 16'h0000;
      $display("split and run test done");
      // a count either way covers the unknown prescaler phase
      for (i = 0; i < 2; i = i + 1) begin
         wb(0, {7'h02, i[0]});
         tk(4);
         l0 = cl;
         tk(120 + 200 * i);
         x = cl - l0 - 8'h09;
         chk({15'h0000, x < 8'h03}, 16'h0001);
      end
      lc <= 1'b1;
      hc <= 1'b0;
      wb(0, 8'h0C);
      tk(4);
      h0 = ch;
      tk(120);
      x = ch - h0 - 8'h09;
      chk({15'h0000, x < 8'h03}, 16'h0001);
      hc <= 1'b1;
      wb(0, 8'h14);
      tk(5);
      lfo <= 1'b0;
      {h0, l0} = {ch, cl};
      for (i = 0; i < 10 && kv !== 1'b1; i = i + 1) tk(1);
      {h0, l0} = {kh, kl} - {h0, l0};
      chk({15'h0000, {h0, l0} < 16'h0008}, 16'h0001);
      chk({15'h0000, irq}, 16'h0001);
      $display("clock and capture test done");
      summarize;
   end
endmodule
